// *** dma_cfg.svh ***
// constants for the dma bus-release and request-sampling block
// assumes inclusion by bare name from dma_bus_release
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define OPR_MASTER_EN_BIT   0
`define OPR_NMI_FLAG_BIT    1
`define OPR_ADDR_ERR_BIT    2
`define OPR_RESET_VAL       16'h0000
`define OPR_ALL_ON_VAL      16'h0001
`define CCR_EN_BIT          0
`define CCR_IE_BIT          2
`define CCR_TS_BIT          3
`define CCR_BURST_BIT       4
`define CCR_EDGE_BIT        5
`define CCR_RS_LSB          8
`define CCR_SM_LSB          12
`define CCR_DM_LSB          14
`define CCR_RESET_VAL       16'h0000
`define CCR_EXAMPLE_VAL     16'h4d0d
`define COUNT_EXAMPLE_VAL   16'h0010
`define RS_EXTERNAL         4'h0
`define SAMPLE_STATE        2'h3
`define UNIT_STATES         2'h2
`endif

// *** dma_pkg.sv ***
// types for the dma bus-release and request-sampling block
// assumes dma_cfg.svh sits in the include path
package dma_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_XFER  = 3'b010,
    ST_REL   = 3'b011
  } bus_state_type;
  typedef logic [1:0] chan_type;
endpackage

// *** dma_regs_if.sv ***
// carrier between the top and the channel memory
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface dma_regs_if;
  logic        wr_en;
  logic [1:0]  wr_idx;
  logic [15:0] wr_cnt;
  logic [1:0]  rd_idx;
  logic [15:0] rd_cnt;
  modport master (output wr_en, output wr_idx, output wr_cnt, output rd_idx, input rd_cnt);
  modport mem    (input wr_en, input wr_idx, input wr_cnt, input rd_idx, output rd_cnt);
endinterface
`default_nettype wire

// *** dma_count_mem.sv ***
// per-channel transfer count storage with registered read data
// assumes one write and one read port on clk_i
`timescale 1ns/100ps
`default_nettype none
module dma_count_mem
(
  input  wire logic clk_i,
  dma_regs_if.mem   regs
);
  logic [15:0] mem_ff [4];
  logic [15:0] rd_ff;
  // registered write and read
  always_ff @(posedge clk_i)
  begin
    if (regs.wr_en)
      mem_ff[regs.wr_idx] <= regs.wr_cnt;
    rd_ff <= mem_ff[regs.rd_idx];
  end
  assign regs.rd_cnt = rd_ff;
endmodule
`default_nettype wire

// *** dma_bus_release.sv ***
// four-channel dma sequencer: bus handshake, nmi halt, request sampling
// assumes cpu grants the bus on bus_grant_i; request pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "dma_cfg.svh"
module dma_bus_release
  import dma_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        opr_wr_i,
  input  wire logic [15:0] opr_wdata_i,
  input  wire logic        ccr_wr_i,
  input  wire logic [1:0]  ccr_idx_i,
  input  wire logic [15:0] ccr_wdata_i,
  input  wire logic        cnt_wr_i,
  input  wire logic [15:0] cnt_wdata_i,
  input  wire logic        end_clr_i,
  input  wire logic [1:0]  end_clr_idx_i,
  input  wire logic        nmi_i,
  input  wire logic        addr_err_i,
  input  wire logic        ext_req_n_i,
  input  wire logic        pin_is_request_i,
  input  wire logic        conv_end_req_i,
  input  wire logic        bus_grant_i,
  output logic             bus_req_o,
  output logic             bus_cycle_o,
  output logic             transfer_ack_o,
  output logic [1:0]       active_chan_o,
  output logic [15:0]      dma_operation_reg_o,
  output logic [3:0]       transfer_end_flag_o,
  output logic             transfer_end_interrupt_o
);
  dma_regs_if regs ();
  dma_count_mem u_mem (.clk_i(clk_i), .regs(regs));

  bus_state_type st_ff, nxt_st;
  logic [15:0] opr_ff, nxt_opr;
  logic [15:0] ccr_ff [4];
  logic [15:0] nxt_ccr [4];
  logic [3:0]  te_ff, nxt_te;
  logic        irq_ff, nxt_irq;
  logic [1:0]  ch_ff, nxt_ch;
  logic [1:0]  cyc_ff, nxt_cyc;
  logic        ack_ff, nxt_ack;
  logic        req_s1_ff, req_s2_ff, req_prev_ff, nxt_req_prev;
  logic        pend_ff, nxt_pend;
  logic        sync_pin_ff, nxt_sync_pin;
  logic [1:0]  pick;
  logic        any_req;
  logic [3:0]  chan_req;
  logic        halted;

  // fixed priority 0 > 3 > 2 > 1
  function automatic logic [1:0] prio_pick(input logic [3:0] r);
    if (r[0])      prio_pick = 2'h0;
    else if (r[3]) prio_pick = 2'h3;
    else if (r[2]) prio_pick = 2'h2;
    else           prio_pick = 2'h1;
  endfunction

  // two-flop synchroniser on the asynchronous request pin
  always_ff @(posedge clk_i)
  begin
    req_s1_ff <= ext_req_n_i;
    req_s2_ff <= req_s1_ff;
  end

  assign halted = opr_ff[`OPR_NMI_FLAG_BIT] | opr_ff[`OPR_ADDR_ERR_BIT];

  // pin reads high while in general-input function; switching in a low pin is an edge
  assign nxt_sync_pin = pin_is_request_i ? req_s2_ff : 1'b1;

  // request decode per channel
  always_comb
  begin
    nxt_req_prev = sync_pin_ff;
    nxt_pend = pend_ff;
    chan_req = 4'h0;
    // latched edge is consumed in the third state counted from the request state,
    // while acknowledge is already asserted; a new edge in that cycle still wins
    if (st_ff == ST_XFER && cyc_ff == `SAMPLE_STATE - 2'h2 && ccr_ff[ch_ff][`CCR_EDGE_BIT])
      nxt_pend = 1'b0;
    if (sync_pin_ff == 1'b0 && req_prev_ff == 1'b1)
      nxt_pend = 1'b1;
    for (int i = 0; i < CHANNELS; i++)
    begin
      chan_req[i] = 1'b0;
      if (ccr_ff[i][`CCR_EN_BIT] && !te_ff[i])
      begin
        if (ccr_ff[i][`CCR_RS_LSB +: 4] == `RS_EXTERNAL)
          chan_req[i] = ccr_ff[i][`CCR_EDGE_BIT] ? pend_ff : ~sync_pin_ff;
        else
          chan_req[i] = conv_end_req_i;
      end
    end
    any_req = opr_ff[`OPR_MASTER_EN_BIT] && !halted && (chan_req != 4'h0);
    pick = prio_pick(chan_req);
  end

  // sequencer, flags and count update
  always_comb
  begin
    nxt_st = st_ff;
    nxt_opr = opr_ff;
    nxt_te = te_ff;
    nxt_irq = 1'b0;
    nxt_ch = ch_ff;
    nxt_cyc = cyc_ff;
    nxt_ack = 1'b0;
    for (int i = 0; i < 4; i++)
      nxt_ccr[i] = ccr_ff[i];
    regs.wr_en = 1'b0;
    regs.wr_idx = ch_ff;
    regs.wr_cnt = regs.rd_cnt - 16'h0001;
    regs.rd_idx = ch_ff;
    if (opr_wr_i)
      nxt_opr = opr_wdata_i & 16'h0007;
    if (ccr_wr_i)
      nxt_ccr[ccr_idx_i] = ccr_wdata_i;
    if (end_clr_i)
      nxt_te[end_clr_idx_i] = 1'b0;
    if (cnt_wr_i)
    begin
      regs.wr_en = 1'b1;
      regs.wr_idx = ccr_idx_i;
      regs.wr_cnt = cnt_wdata_i;
    end
    case (st_ff)
      ST_IDLE:
      begin
        if (any_req)
        begin
          nxt_ch = pick;
          nxt_st = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (halted || !opr_ff[`OPR_MASTER_EN_BIT])
          nxt_st = ST_IDLE;
        else if (bus_grant_i)
        begin
          nxt_cyc = 2'h0;
          nxt_ack = 1'b1;
          nxt_st = ST_XFER;
        end
      end
      ST_XFER:
      begin
        nxt_cyc = cyc_ff + 2'h1;
        nxt_ack = 1'b1;
        if (!bus_grant_i || halted)
          nxt_st = ST_REL;
        else if (cyc_ff == `UNIT_STATES - 2'h1)
        begin
          nxt_cyc = 2'h0;
          if (!cnt_wr_i)
            regs.wr_en = 1'b1;
          if (regs.rd_cnt == 16'h0001)
          begin
            nxt_te[ch_ff] = 1'b1;
            nxt_irq = ccr_ff[ch_ff][`CCR_IE_BIT];
            nxt_st = ST_REL;
          end
          else if (!ccr_ff[ch_ff][`CCR_BURST_BIT])
            nxt_st = ST_REL;
          else if (!ccr_ff[ch_ff][`CCR_EN_BIT] || !opr_ff[`OPR_MASTER_EN_BIT])
            nxt_st = ST_REL;
          // burst keeps the bus until count end, channel or master disable, grant loss or a halt flag
          else
            nxt_st = ST_XFER;
        end
      end
      ST_REL:
      begin
        nxt_st = ST_IDLE;
      end
      default:
      begin
        nxt_st = ST_IDLE;
      end
    endcase
    // nmi and address error win over software writes to the operation register
    if (nmi_i)
      nxt_opr[`OPR_NMI_FLAG_BIT] = 1'b1;
    if (addr_err_i)
      nxt_opr[`OPR_ADDR_ERR_BIT] = 1'b1;
  end

  // state registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= ST_IDLE;
      opr_ff <= `OPR_RESET_VAL;
      te_ff <= 4'h0;
      irq_ff <= 1'b0;
      ch_ff <= 2'h0;
      cyc_ff <= 2'h0;
      ack_ff <= 1'b0;
      pend_ff <= 1'b0;
      req_prev_ff <= 1'b1;
      sync_pin_ff <= 1'b1;
      for (int i = 0; i < 4; i++)
        ccr_ff[i] <= `CCR_RESET_VAL;
    end
    else
    begin
      st_ff <= nxt_st;
      opr_ff <= nxt_opr;
      te_ff <= nxt_te;
      irq_ff <= nxt_irq;
      ch_ff <= nxt_ch;
      cyc_ff <= nxt_cyc;
      ack_ff <= nxt_ack;
      pend_ff <= nxt_pend;
      req_prev_ff <= nxt_req_prev;
      sync_pin_ff <= nxt_sync_pin;
      for (int i = 0; i < 4; i++)
        ccr_ff[i] <= nxt_ccr[i];
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_req_o <= 1'b0;
      bus_cycle_o <= 1'b0;
      transfer_ack_o <= 1'b0;
      active_chan_o <= 2'h0;
      dma_operation_reg_o <= `OPR_RESET_VAL;
      transfer_end_flag_o <= 4'h0;
      transfer_end_interrupt_o <= 1'b0;
    end
    else
    begin
      bus_req_o <= (nxt_st == ST_REQ) || (nxt_st == ST_XFER);
      bus_cycle_o <= (nxt_st == ST_XFER) && bus_grant_i;
      transfer_ack_o <= nxt_ack && (nxt_st == ST_XFER);
      active_chan_o <= nxt_ch;
      dma_operation_reg_o <= nxt_opr;
      transfer_end_flag_o <= nxt_te;
      transfer_end_interrupt_o <= nxt_irq;
    end
  end
endmodule
`default_nettype wire

// *** dma_bus_release_properties.sv ***
// checker for bus handshake, halt flag and end pulse
// assumes binding onto the ports of dma_bus_release
`timescale 1ns/100ps
`default_nettype none
module dma_bus_release_properties
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        nmi_i,
  input wire logic        bus_grant_i,
  input wire logic        bus_req_o,
  input wire logic        bus_cycle_o,
  input wire logic        transfer_ack_o,
  input wire logic [15:0] dma_operation_reg_o,
  input wire logic [3:0]  transfer_end_flag_o,
  input wire logic        transfer_end_interrupt_o
);
  logic halt;
  // new units are blocked while halted or master enable is off
  assign halt = dma_operation_reg_o[1] | dma_operation_reg_o[2] | !dma_operation_reg_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  grant_held_a: assert property (bus_cycle_o |-> $past(bus_grant_i)) else $error("no grant");
  nmi_flag_a: assert property (nmi_i |=> dma_operation_reg_o[1]) else $error("nmi flag");
  nmi_stop_a: assert property (nmi_i |-> ##[1:6] !bus_cycle_o) else $error("nmi stop");
  unit_len_a: assert property ($rose(bus_cycle_o) |=> bus_cycle_o) else $error("unit");
  ack_cycle_a: assert property (transfer_ack_o |-> bus_cycle_o) else $error("ack");
  irq_flag_a: assert property (transfer_end_interrupt_o |-> |transfer_end_flag_o) else $error("end");
  irq_pulse_a: assert property (transfer_end_interrupt_o |=> !transfer_end_interrupt_o) else $error("pulse");
  halt_block_a: assert property (halt [*3] |-> !$rose(bus_req_o)) else $error("halted");
  cover property ($rose(bus_cycle_o));
  cover property (transfer_end_interrupt_o);
  cover property (nmi_i);
endmodule
bind dma_bus_release dma_bus_release_properties u_props (.*);
`default_nettype wire

// *** dma_cpu_model.sv ***
// cpu bus master that grants the bus after its own access ends
// assumes bus requests from the dma block on clk_i
`timescale 1ns/100ps
`default_nettype none
module dma_cpu_model
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic bus_req_i,
  output logic      bus_grant_o
);
  logic [1:0] wait_ff;
  // slow mode finishes a cpu access of three cycles first
  always_ff @(posedge clk_i)
    if (rst_i || !bus_req_i)
    begin
      bus_grant_o <= 1'b0;
      wait_ff     <= slow_i ? 2'h3 : 2'h0;
    end
    else if (wait_ff != 2'h0)
      wait_ff <= wait_ff - 2'h1;
    else
      bus_grant_o <= 1'b1;
endmodule
`default_nettype wire

// *** tb_dma_bus_release.sv ***
// self-checking bench for the dma sequencer
// assumes dma_cpu_model answers bus requests
`timescale 1ns/100ps
`default_nettype none
module tb_dma_bus_release;
  logic        clk_i, rst_i, opr_wr_i, ccr_wr_i, cnt_wr_i, end_clr_i, nmi_i, addr_err_i;
  logic        ext_req_n_i, pin_is_request_i, conv_end_req_i, bus_grant_i, slow;
  logic        bus_req_o, bus_cycle_o, transfer_ack_o, transfer_end_interrupt_o;
  logic [1:0]  ccr_idx_i, end_clr_idx_i, active_chan_o;
  logic [3:0]  transfer_end_flag_o;
  logic [15:0] opr_wdata_i, ccr_wdata_i, cnt_wdata_i, dma_operation_reg_o, units;
  logic [15:0] exp_q[$];
  int          fail_count, n_tests;
  dma_bus_release dut_u (.*);
  dma_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
                       .bus_req_i(bus_req_o), .bus_grant_o(bus_grant_i));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one write pulse: 0 operation, 1 control, 2 count, 3 end clear
  task automatic put(input int k, input logic [1:0] ch, input logic [15:0] d);
    @(posedge clk_i);
    {ccr_idx_i, end_clr_idx_i} <= {ch, ch};
    {opr_wdata_i, ccr_wdata_i, cnt_wdata_i} <= {d, d, d};
    {opr_wr_i, ccr_wr_i, cnt_wr_i, end_clr_i} <= {k == 0, k == 1, k == 2, k == 3};
    @(posedge clk_i);
    {opr_wr_i, ccr_wr_i, cnt_wr_i, end_clr_i} <= 4'h0;
  endtask
  // note expectations, start a channel, wait for its end, then disable it
  task automatic run(input logic [1:0] ch, input logic [15:0] ccr, input logic [15:0] n);
    exp_q.push_back(16'h1 << ch);
    exp_q.push_back({14'h0, ch});
    exp_q.push_back(n << 1);
    put(2, ch, n);
    put(1, ch, ccr);
    pin_is_request_i <= 1'b1;
    while (exp_q.size() != 0) @(posedge clk_i);
    put(1, ch, 16'h0);
    put(3, ch, 16'h0);
  endtask
  // count transfer states and judge every end pulse
  always @(posedge clk_i)
  begin
    units <= rst_i ? 16'h0 : units + {15'h0, transfer_ack_o === 1'b1};
    if (transfer_end_interrupt_o === 1'b1 && exp_q.size() > 2)
    begin
      check({12'h0, transfer_end_flag_o}, exp_q.pop_front());
      check({14'h0, active_chan_o}, exp_q.pop_front());
      check(units + {15'h0, transfer_ack_o}, exp_q.pop_front());
      units <= 16'h0;
    end
    else if (transfer_end_interrupt_o === 1'b1)
      check(16'h1, 16'h0);
  end
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog sized well above the whole sequence
  initial
  begin
    #200000;
    fail_count++;
    conclude();
  end
  initial
  begin
    {rst_i, ext_req_n_i, conv_end_req_i} = 3'h5;
    {opr_wr_i, ccr_wr_i, cnt_wr_i, end_clr_i, nmi_i, addr_err_i, pin_is_request_i, slow} = 8'h0;
    {ccr_idx_i, end_clr_idx_i, opr_wdata_i, ccr_wdata_i, cnt_wdata_i} = '0;
    {fail_count, n_tests} = '0;
    void'($urandom(61));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    put(0, 2'h0, 16'h0001);
    run(2'h0, 16'h0025, 16'h1);
    run(2'h2, 16'h0005, 16'h2);
    ext_req_n_i <= 1'b1;
    repeat (4)
    begin
      slow <= 1'($urandom);
      run(2'($urandom), 16'h0105, 16'($urandom % 3 + 1));
    end
    run(2'h3, 16'h4d0d, 16'h0010);
    @(posedge clk_i);
    nmi_i <= 1'b1;
    @(posedge clk_i);
    nmi_i <= 1'b0;
    @(negedge clk_i);
    check(dma_operation_reg_o, 16'h0003);
    put(2, 2'h1, 16'h1);
    put(1, 2'h1, 16'h0105);
    repeat (20) @(negedge clk_i);
    check({15'h0, bus_req_o}, 16'h0);
    put(1, 2'h1, 16'h0);
    put(0, 2'h0, 16'h0001);
    run(2'h1, 16'h0105, 16'h1);
    // nmi in the middle of a burst drops the bus and leaves the end flag clear
    put(2, 2'h2, 16'h0008);
    put(1, 2'h2, 16'h0115);
    while (bus_cycle_o !== 1'b1) @(posedge clk_i);
    nmi_i <= 1'b1;
    @(posedge clk_i);
    nmi_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    check({15'h0, bus_req_o}, 16'h0);
    check({12'h0, transfer_end_flag_o}, 16'h0);
    // second reset clears the halt flag and every channel's control and end flag
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    put(0, 2'h0, 16'h0001);
    run(2'h2, 16'h0115, 16'h5);
    conclude();
  end
endmodule
`default_nettype wire
